//--- hdl/edge_counter_timestamp.sv
// Two-channel falling edge counter with per-edge byte store and timestamp
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Counts advance only on high-to-low edges: of the selected input, or in width mode of the reference clock.
// - Two channels count independently of each other.
// - Three shared digital inputs and a differential receiver feed the channels.
// - Reference clock source selectable, rate 600 kHz down to 300 Hz.
// - Each channel's own count register does the counting; edges up to about 600 kHz.
// - Each counted edge can store one port byte.
// - Stored byte may be the free-running timer low byte.
// - Timestamp mode stores one byte then interrupts; software reads upper bits.
// - Hardware range 65,536 edges; software extends below about 10 kHz.
// - Pulse width measured by counting reference cycles while input is low.
// - Fast counting capped at 65,536; slow counting unlimited via extension.
module edge_counter_timestamp
  import edge_counter_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [2:0]             shared_counter_digital_inputs,
  input  wire logic                   counter_two_diff_positive,
  input  wire logic                   counter_two_diff_negative,
  input  wire chan_cfg_s [NUM_CH-1:0] chan_cfg,
  input  wire logic [REF_DIV_W-1:0]   ref_half_period,
  input  wire logic [BYTE_W-1:0]      io_port_byte,
  input  wire logic [NUM_CH-1:0]      stamp_ack,
  input  wire logic [TIMER_W-1:0]     timer_reload,
  output logic [NUM_CH-1:0][COUNT_W-1:0] count,
  output logic [NUM_CH-1:0]           wrap_pulse,
  output var store_beat_s [NUM_CH-1:0] store_beat,
  output logic [NUM_CH-1:0]           stamp_irq,
  output logic [TIMER_W-1:0]          free_running_reload_timer,
  output logic                        serial_reference_clock_out,
  output logic [2:0]                  digital_level
);

  // ---------------------------------------------------------------
  // Input mapping
  // ---------------------------------------------------------------
  logic counter_one_input_a;
  logic counter_one_input_b;
  logic counter_two_input_a;
  logic diff_level;
  logic ref_clk;

  assign counter_one_input_a = shared_counter_digital_inputs[0];
  assign counter_one_input_b = shared_counter_digital_inputs[1];
  assign counter_two_input_a = shared_counter_digital_inputs[2];

  // Differential receiver reduced to a compare of the two legs
  assign diff_level = counter_two_diff_positive & ~counter_two_diff_negative;

  // Shared pins still read as ordinary digital inputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      digital_level <= 3'h0;
    end else begin
      digital_level <= shared_counter_digital_inputs;
    end
  end

  // ---------------------------------------------------------------
  // Reference clock
  // ---------------------------------------------------------------
  reference_clock_gen u_ref (
    .clk         (clk),
    .rst         (rst),
    .half_period (ref_half_period),
    .ref_clk     (ref_clk)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_reference_clock_out <= 1'b1;
    end else begin
      serial_reference_clock_out <= ref_clk;
    end
  end

  // ---------------------------------------------------------------
  // Free-running timer, counts down and reloads
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      free_running_reload_timer <= TIMER_RESET;
    end else if (free_running_reload_timer == '0) begin
      free_running_reload_timer <= timer_reload;
    end else begin
      free_running_reload_timer <= free_running_reload_timer - TIMER_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // Per-channel counting
  // ---------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      logic pin_a;
      logic pin_b;
      logic chosen_level;
      logic chosen_fall;
      logic ref_fall;
      logic pulse_low;
      logic count_event;
      logic store_take;
      logic stamp_take;

      // Channel two has no second pin; its b source is the receiver
      if (ch == 0) begin : g_pins_one
        assign pin_a = counter_one_input_a;
        assign pin_b = counter_one_input_b;
      end else begin : g_pins_two
        assign pin_a = counter_two_input_a;
        assign pin_b = diff_level;
      end

      // A source change from a high level onto a low level reads as one edge
      always_comb begin
        if (chan_cfg[ch].src == SRC_PIN_B) begin
          chosen_level = pin_b;
        end else if (chan_cfg[ch].src == SRC_REFCLK) begin
          chosen_level = ref_clk;
        end else begin
          chosen_level = pin_a;
        end
      end

      falling_edge_detect u_edge (
        .clk   (clk),
        .rst   (rst),
        .level (chosen_level),
        .fall  (chosen_fall)
      );

      falling_edge_detect u_ref_edge (
        .clk   (clk),
        .rst   (rst),
        .level (ref_clk),
        .fall  (ref_fall)
      );

      // Width mode gates reference edges by a low input level
      assign pulse_low = ~chosen_level;
      assign count_event = chan_cfg[ch].enable &&
                           (chan_cfg[ch].width_mode ? (ref_fall && pulse_low)
                                                    : chosen_fall);
      assign store_take = count_event && (chan_cfg[ch].mode == MODE_STORE);
      // Edges while the interrupt is pending are not stamped: spacing is the source's duty
      assign stamp_take = count_event && (chan_cfg[ch].mode == MODE_STAMP) && !stamp_irq[ch];

      // Each channel owns its count; 16 bits give 65,536 states
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          count[ch] <= COUNT_RESET;
        end else if (count_event) begin
          count[ch] <= count[ch] + COUNT_W'(1);
        end
      end

      // Wrap flag lets software extend slow counts; fast ones stay capped
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          wrap_pulse[ch] <= 1'b0;
        end else begin
          wrap_pulse[ch] <= count_event && (count[ch] == COUNT_MAX);
        end
      end

      // Byte store per edge, or one shot in timestamp mode
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          store_beat[ch] <= '0;
        end else begin
          store_beat[ch].valid <= store_take || stamp_take;
          if (store_take) begin
            store_beat[ch].data <= io_port_byte;
          end else if (stamp_take) begin
            store_beat[ch].data <= free_running_reload_timer[BYTE_W-1:0];
          end
        end
      end

      // Set beats a same-cycle ack so no stamp is lost
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stamp_irq[ch] <= 1'b0;
        end else if (stamp_take) begin
          stamp_irq[ch] <= 1'b1;
        end else if (stamp_ack[ch]) begin
          stamp_irq[ch] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : edge_counter_timestamp
`default_nettype wire

//--- hdl/edge_counter_pkg.sv
// Shared constants and carrier types for the edge counter block
package edge_counter_pkg;

  localparam int CLK_HZ          = 20_000_000;
  localparam int MAX_EDGE_HZ     = 600_000;
  localparam int MIN_REF_HZ      = 300;
  localparam int COUNT_W         = 16;
  localparam int TIMER_W         = 16;
  localparam int BYTE_W          = 8;
  localparam int NUM_CH          = 2;
  localparam int SRC_W           = 2;
  // Source selections per channel
  localparam logic [SRC_W-1:0] SRC_PIN_A  = 2'h0;
  localparam logic [SRC_W-1:0] SRC_PIN_B  = 2'h1;
  localparam logic [SRC_W-1:0] SRC_REFCLK = 2'h2;
  // Reference divider: 20 MHz / (2*N) gives 600 kHz down to 300 Hz
  localparam int REF_DIV_MIN     = (CLK_HZ + 2 * MAX_EDGE_HZ - 1) / (2 * MAX_EDGE_HZ);
  localparam int REF_DIV_MAX     = CLK_HZ / (2 * MIN_REF_HZ);
  localparam int REF_DIV_W       = 16;
  localparam logic [REF_DIV_W-1:0] REF_DIV_RESET = 16'h0011;
  localparam logic [COUNT_W-1:0]   COUNT_RESET   = 16'h0000;
  localparam logic [COUNT_W-1:0]   COUNT_MAX     = 16'hFFFF;
  localparam logic [TIMER_W-1:0]   TIMER_RESET   = 16'hFFFF;

  typedef enum logic [2:0] {
    MODE_COUNT = 3'h1,
    MODE_STORE = 3'h2,
    MODE_STAMP = 3'h4
  } chan_mode_e;

  typedef struct packed {
    logic             enable;
    chan_mode_e       mode;
    logic [SRC_W-1:0] src;
    logic             width_mode;
  } chan_cfg_s;

  typedef struct packed {
    logic              valid;
    logic [BYTE_W-1:0] data;
  } store_beat_s;

endpackage : edge_counter_pkg

//--- hdl/reference_clock_gen.sv
// Programmable serial-port style reference clock divider
`timescale 1ns/1ps
`default_nettype none
module reference_clock_gen
  import edge_counter_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [REF_DIV_W-1:0] half_period,
  output logic                      ref_clk
);

  logic [REF_DIV_W-1:0] div_count;
  logic [REF_DIV_W-1:0] limit;

  // Clamp keeps rate inside 600 kHz .. 300 Hz
  always_comb begin
    if (half_period < REF_DIV_W'(REF_DIV_MIN)) begin
      limit = REF_DIV_W'(REF_DIV_MIN);
    end else if (half_period > REF_DIV_W'(REF_DIV_MAX)) begin
      limit = REF_DIV_W'(REF_DIV_MAX);
    end else begin
      limit = half_period;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_count <= '0;
      ref_clk   <= 1'b1;
    end else if (div_count >= limit - REF_DIV_W'(1)) begin
      div_count <= '0;
      ref_clk   <= ~ref_clk;
    end else begin
      div_count <= div_count + REF_DIV_W'(1);
    end
  end

endmodule : reference_clock_gen
`default_nettype wire

//--- hdl/falling_edge_detect.sv
// Falling edge detector for one counter input
`timescale 1ns/1ps
`default_nettype none
module falling_edge_detect (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic level,
  output logic      fall
);

  logic prev;

  // Idle high so a reset does not fake an edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= 1'b1;
    end else begin
      prev <= level;
    end
  end

  assign fall = prev & ~level;

endmodule : falling_edge_detect
`default_nettype wire

//--- tb/pulse_source_model.sv
// Model of the external pulse sources on the counter inputs
`timescale 1ns/1ps
`default_nettype none
module pulse_source_model (
  input  wire logic  clk,
  output logic [2:0] pins,
  output logic       diff_p,
  output logic       diff_n
);
  initial begin
    pins = 3'h7;
    diff_p = 1'b1;
    diff_n = 1'b0;
  end
  // Index 3 is the differential pair; level is pos and not neg
  task automatic pulse(input int idx, input int low_cyc);
    @(negedge clk);
    if (idx == 3) diff_p = 1'b0;
    else pins[idx] = 1'b0;
    repeat (low_cyc) @(negedge clk);
    if (idx == 3) diff_p = 1'b1;
    else pins[idx] = 1'b1;
    // High for two samples, so the detector sees high again before the next fall
    repeat (2) @(negedge clk);
  endtask : pulse
endmodule : pulse_source_model
`default_nettype wire

//--- tb/edge_counter_monitor.sv
// Port-level assertions for the edge counter
`timescale 1ns/1ps
`default_nettype none
module edge_counter_monitor
  import edge_counter_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic [2:0]                 shared_counter_digital_inputs,
  input wire chan_cfg_s [NUM_CH-1:0]     chan_cfg,
  input wire logic [BYTE_W-1:0]          io_port_byte,
  input wire logic [NUM_CH-1:0]          stamp_ack,
  input wire logic [NUM_CH-1:0][COUNT_W-1:0] count,
  input wire logic [NUM_CH-1:0]          wrap_pulse,
  input wire store_beat_s [NUM_CH-1:0]   store_beat,
  input wire logic [NUM_CH-1:0]          stamp_irq,
  input wire logic [TIMER_W-1:0]         free_running_reload_timer,
  input wire logic                       serial_reference_clock_out
);
  wire logic [7:0] tl = free_running_reload_timer[7:0];
  wire logic go0 = chan_cfg[0].enable && chan_cfg[0].src == SRC_PIN_A && !chan_cfg[0].width_mode;
  wire logic go1 = chan_cfg[1].enable && chan_cfg[1].src == SRC_PIN_A && !chan_cfg[1].width_mode;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // Properties
  // ----
  sequence s_edge0;
    go0 && $fell(shared_counter_digital_inputs[0]);
  endsequence
  sequence s_stamp;
    go1 && $fell(shared_counter_digital_inputs[2]) && chan_cfg[1].mode == MODE_STAMP && !stamp_irq[1];
  endsequence
  sequence s_beat1;
    store_beat[1].valid && stamp_irq[1];
  endsequence
  property p_fall_count;
    s_edge0 |=> count[0] == $past(count[0]) + 16'h0001;
  endproperty
  a_fall_count: assert property (p_fall_count) else $error("count missed a falling edge");
  property p_hold;
    go0 && !$fell(shared_counter_digital_inputs[0]) |=> $stable(count[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved without a falling edge");
  property p_idle;
    !chan_cfg[1].enable |=> $stable(count[1]);
  endproperty
  a_idle: assert property (p_idle) else $error("disabled channel counted");
  property p_wrap;
    s_edge0 ##0 (count[0] == COUNT_MAX) |=> count[0] == COUNT_RESET && wrap_pulse[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at maximum");
  property p_wrap_src;
    wrap_pulse[0] |-> count[0] == COUNT_RESET && $past(count[0]) == COUNT_MAX;
  endproperty
  a_wrap_src: assert property (p_wrap_src) else $error("wrap flag without wrap");
  property p_store;
    s_edge0 ##0 (chan_cfg[0].mode == MODE_STORE) |=> store_beat[0].valid && store_beat[0].data == $past(io_port_byte);
  endproperty
  a_store: assert property (p_store) else $error("port byte not stored");
  // Edges cannot come closer than two cycles, so a beat never repeats
  property p_beat_once;
    store_beat[0].valid |=> !store_beat[0].valid;
  endproperty
  a_beat_once: assert property (p_beat_once) else $error("beat longer than one cycle");
  property p_stamp;
    s_stamp |=> s_beat1 ##0 (store_beat[1].data == $past(tl));
  endproperty
  a_stamp: assert property (p_stamp) else $error("timestamp beat wrong");
  property p_irq_hold;
    stamp_irq[1] && !stamp_ack[1] |=> stamp_irq[1] && !store_beat[1].valid;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("stamp irq dropped or extra beat");
  property p_set_wins;
    s_stamp ##0 stamp_ack[1] |=> stamp_irq[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("stamp lost to a same-cycle clear");
  // Half period is clamped to 17 cycles or more
  property p_ref_hold;
    $changed(serial_reference_clock_out) |=> $stable(serial_reference_clock_out) [*8];
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference half period too short");
  property p_timer;
    free_running_reload_timer != 16'h0000 |=> free_running_reload_timer == $past(free_running_reload_timer) - 16'h0001;
  endproperty
  a_timer: assert property (p_timer) else $error("timer not counting down");
endmodule : edge_counter_monitor
bind edge_counter_timestamp edge_counter_monitor mon_u (.clk(clk), .rst(rst),
  .shared_counter_digital_inputs(shared_counter_digital_inputs), .chan_cfg(chan_cfg), .io_port_byte(io_port_byte),
  .stamp_ack(stamp_ack), .count(count), .wrap_pulse(wrap_pulse), .store_beat(store_beat), .stamp_irq(stamp_irq),
  .free_running_reload_timer(free_running_reload_timer), .serial_reference_clock_out(serial_reference_clock_out));
`default_nettype wire

//--- tb/edge_counter_timestamp_test.sv
// Self-checking bench for the two-channel edge counter
`timescale 1ns/1ps
`default_nettype none
module edge_counter_timestamp_test
  import edge_counter_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire logic [2:0] pins;
  wire logic diff_p;
  wire logic diff_n;
  chan_cfg_s [NUM_CH-1:0] chan_cfg;
  logic [REF_DIV_W-1:0] ref_half = REF_DIV_RESET;
  logic [BYTE_W-1:0] port_byte = 8'h00;
  logic [NUM_CH-1:0] ack = 2'h0;
  logic [NUM_CH-1:0][COUNT_W-1:0] count;
  logic [NUM_CH-1:0] irq;
  store_beat_s [NUM_CH-1:0] beat;
  logic [2:0] dig;
  logic [7:0] last0 = 8'h00;
  logic [COUNT_W-1:0] exp0 = 16'h0000;
  logic [COUNT_W-1:0] exp1 = 16'h0000;
  int mismatches = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (beat[0].valid === 1'b1) last0 <= beat[0].data;
  pulse_source_model src_u (.clk(clk), .pins(pins), .diff_p(diff_p), .diff_n(diff_n));
  edge_counter_timestamp dut_u (.clk(clk), .rst(rst), .shared_counter_digital_inputs(pins),
    .counter_two_diff_positive(diff_p), .counter_two_diff_negative(diff_n), .chan_cfg(chan_cfg),
    .ref_half_period(ref_half), .io_port_byte(port_byte), .stamp_ack(ack), .timer_reload(16'h00FF),
    .count(count), .wrap_pulse(), .store_beat(beat), .stamp_irq(irq), .free_running_reload_timer(),
    .serial_reference_clock_out(), .digital_level(dig));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // ----
  // Scenarios
  // ----
  task automatic t_count();
    chan_cfg[0] = '{1'b1, MODE_COUNT, SRC_PIN_A, 1'b0};
    for (int i = 0; i < 3; i++) src_u.pulse(i % 2, 1 + i);
    src_u.pulse(2, 1);
    exp0 += 16'h0002;
    check(count[0], exp0);
    check(count[1], exp1);
    $display("t_count done");
  endtask : t_count
  task automatic t_store();
    chan_cfg[0].mode = MODE_STORE;
    for (int i = 0; i < 2; i++) begin
      port_byte = i ? 8'hC3 : 8'h5A;
      src_u.pulse(0, 1);
      exp0++;
      check(last0, port_byte);
    end
    check(count[0], exp0);
    $display("t_store done");
  endtask : t_store
  task automatic t_stamp();
    chan_cfg[1] = '{1'b1, MODE_STAMP, SRC_PIN_A, 1'b0};
    src_u.pulse(2, 1);
    check(irq[1], 1'b1);
    // Second edge before service: counted, no new stamp
    src_u.pulse(2, 1);
    exp1 += 16'h0002;
    check(count[1], exp1);
    ack[1] = 1'b1;
    @(negedge clk);
    ack[1] = 1'b0;
    @(negedge clk);
    check(irq[1], 1'b0);
    // Edge and clear in one cycle: the new stamp must win
    fork
      src_u.pulse(2, 1);
      begin
        @(negedge clk);
        ack[1] = 1'b1;
        @(negedge clk);
        ack[1] = 1'b0;
      end
    join
    exp1++;
    check(irq[1], 1'b1);
    check(count[1], exp1);
    ack[1] = 1'b1;
    @(negedge clk);
    ack[1] = 1'b0;
    @(negedge clk);
    $display("t_stamp done");
  endtask : t_stamp
  task automatic t_diff();
    chan_cfg[1] = '{1'b1, MODE_COUNT, SRC_PIN_B, 1'b0};
    src_u.pulse(3, 2);
    exp1++;
    check(count[1], exp1);
    // Channel one pin b low: the plain digital copy follows it
    fork
      src_u.pulse(1, 4);
      begin
        repeat (3) @(negedge clk);
        check(dig, 3'h5);
      end
    join
    $display("t_diff done");
  endtask : t_diff
  task automatic t_width();
    logic [15:0] d;
    chan_cfg[0] = '{1'b1, MODE_COUNT, SRC_PIN_A, 1'b1};
    // Reference period 34 cycles; 340 low cycles hold exactly ten falls
    src_u.pulse(0, 340);
    d = count[0] - exp0;
    check(d, 16'h000A);
    $display("t_width done");
  endtask : t_width
  task automatic t_src();
    logic [15:0] base;
    logic [15:0] d;
    chan_cfg[0] = '{1'b1, MODE_COUNT, SRC_PIN_B, 1'b0};
    base = count[0];
    src_u.pulse(1, 1);
    src_u.pulse(0, 1);
    check(count[0], base + 16'h0001);
    // Reference routed in; the switch itself may add one edge
    chan_cfg[0].src = SRC_REFCLK;
    base = count[0];
    repeat (340) @(negedge clk);
    d = count[0] - base;
    check({15'h0000, d >= 16'h000A && d <= 16'h000B}, 16'h0001);
    $display("t_src done");
  endtask : t_src
  initial begin
    chan_cfg = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_count();
    t_store();
    t_stamp();
    t_diff();
    t_width();
    t_src();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : edge_counter_timestamp_test
`default_nettype wire
